// File: hw/rtdm_top.sv
// Descriptor and buffer manager of the remote terminal with shared RAM and register slave
// Notes on behaviour
// - 32K-word space; first 80 words are registers, rest shared RAM.
// - Host port carries 16-bit data, word addresses, selects, interrupt output.
// - After master reset, self-test runs, then ready rises; host waits for it.
// - Terminal runs only with control bit 6 set and enable pin high.
// - Start-execution bit, set last by host, starts terminal execution.
// - One four-word control block per subaddress and per mode code, each direction.
// - Table defaults to 0x0400-0x05FF; moves with the base address register.
// - Receive subaddress blocks at 0x400, transmit at 0x480, by subaddress.
// - Subaddress 0 or 31 is mode code; receive 0x500, transmit 0x580.
// - Word one control, words two/three per scheme, word four broadcast pointer.
// - Accessing a block sets its block-accessed flag in the control word.
// - Control bits 2-0 pick ping-pong, indexed, circular 1 or circular 2; circular ones use pointer A without update.
// - Broadcast pointer used only for broadcast commands.
// - Ping-pong alternates between pointers A and B on successive messages.
// - Next-pointer-select high picks B, low picks A; device maintains it.
// - Indexed uses A; broadcast receive to word four when Notice II set.
// - After error-free indexed message pointer A advances by N plus 2.
// - Index count decrements; buffer-full interrupt when count goes 1 to 0.
// - With index zero, later messages reuse the last buffer range.
// - Index already zero: no decrement, pointer A unchanged.
// - On release of master reset all shared RAM words clear to zero.
`timescale 1ns/10ps
module rtdm_top (
  // Clock, reset, enable
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  // AXI4-Lite write address
  input  wire logic [16:0]          awaddr,
  input  wire logic [2:0]           awprot,
  input  wire logic                 awvalid,
  output logic                      awready,
  // AXI4-Lite write data
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  // AXI4-Lite write response
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  // AXI4-Lite read address
  input  wire logic [16:0]          araddr,
  input  wire logic [2:0]           arprot,
  input  wire logic                 arvalid,
  output logic                      arready,
  // AXI4-Lite read data
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // Board pins
  input  wire logic                 terminal_one_enable,
  output logic                      ready,
  output logic                      buf_full_irq,
  // Completed message from the protocol engine
  input  wire logic                 msg_valid,
  output logic                      msg_ready,
  input  wire rtdm_pkg::rtdm_msg_s  msg,
  // Buffer chosen for the message
  output logic                      done_valid,
  output rtdm_pkg::rtdm_done_s      done_info
);

  typedef struct packed {
    rtdm_pkg::rtdm_st_e st;
    logic [14:0]        clr_addr;
    logic               ready;
    logic [15:0]        master_control_reg;
    logic [15:0]        cfg;
    logic [15:0]        dtbase;
    logic [2:0]         ena_sync;
    logic               ena_pin;
    logic               aw_full;
    logic [14:0]        aw_addr;
    logic               w_full;
    logic [15:0]        w_data;
    logic [1:0]         w_be;
    logic               bvalid;
    logic               ar_full;
    logic [14:0]        ar_addr;
    logic               rvalid;
    logic [15:0]        rdata;
    rtdm_pkg::rtdm_msg_s msg;
    logic [14:0]        desc;
    logic [15:0]        cw;
    logic [15:0]        pa;
    logic [15:0]        pb;
    logic               done;
    rtdm_pkg::rtdm_done_s done_info;
    logic               irq;
  } rtdm_state_s;

  rtdm_state_s r;
  rtdm_state_s next_r;

  logic [15:0] mem [0:rtdm_pkg::RAM_WORDS-1];
  logic [15:0] mem_rdata;
  logic [14:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [1:0]  mem_be;
  logic        mem_we;

  // Subaddress 0 or 31 marks a mode code command
  function automatic logic is_mode(input rtdm_pkg::rtdm_msg_s m);
    return (m.subaddr_number == rtdm_pkg::SA_MODE_LO) || (m.subaddr_number == rtdm_pkg::SA_MODE_HI);
  endfunction

  // Control block address inside the table
  function automatic logic [14:0] desc_ofs(input rtdm_pkg::rtdm_msg_s m);
    logic        mc;
    logic [14:0] q;
    logic [4:0]  idx;
    mc  = is_mode(m);
    q   = m.tx ? (mc ? rtdm_pkg::Q_TX_MC : rtdm_pkg::Q_TX_SA)
               : (mc ? rtdm_pkg::Q_RX_MC : rtdm_pkg::Q_RX_SA);
    idx = mc ? m.wc_mode : m.subaddr_number;
    return q + {8'h00, idx, 2'b00};
  endfunction

  // Data words carried by the message
  function automatic logic [5:0] data_words(input rtdm_pkg::rtdm_msg_s m);
    // Mode codes 16 to 31 carry one data word
    if (is_mode(m)) begin
      return {5'h00, m.wc_mode[4]};
    end
    return (m.wc_mode == 5'h00) ? rtdm_pkg::FULL_WC : {1'b0, m.wc_mode};
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] be);
    return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  logic        running;
  logic        bc_sel;
  logic [15:0] bp_word;
  logic [15:0] next_cw;
  logic [15:0] next_pa;
  logic [15:0] next_pb;
  logic [14:0] buf_sel;
  logic        full_evt;

  always_comb begin
    running = r.ready && r.master_control_reg[rtdm_pkg::MCR_ENA_BIT] && r.ena_pin && r.master_control_reg[rtdm_pkg::MCR_STEX_BIT];
    bc_sel  = r.msg.bcast && r.cfg[rtdm_pkg::CFG_NOTICE2_BIT];
    bp_word = mem_rdata;
    next_cw = r.cw | (16'h0001 << rtdm_pkg::CW_BLOCK_ACCESSED_FLAG_BIT);
    next_pa = r.pa;
    next_pb = r.pb;
    buf_sel = r.pa[14:0];
    full_evt = 1'b0;
    // Circular schemes fall back to pointer A without update
    case (r.cw[2:0])
      rtdm_pkg::SCH_PINGPONG: begin
        if (bc_sel) begin
          buf_sel = bp_word[14:0];
        end else begin
          buf_sel = r.cw[rtdm_pkg::CW_NPS_BIT] ? r.pb[14:0] : r.pa[14:0];
          if (!r.msg.error) begin
            next_cw[rtdm_pkg::CW_NPS_BIT] = ~r.cw[rtdm_pkg::CW_NPS_BIT];
          end
        end
      end
      rtdm_pkg::SCH_INDEXED: begin
        if (bc_sel && !r.msg.tx) begin
          buf_sel = bp_word[14:0];
        end else if (!r.msg.error && (r.pb != 16'h0000)) begin
          // Errored messages and a spent index leave both words alone
          next_pa  = r.pa + rtdm_pkg::MSG_INFO_WORDS + {10'h000, data_words(r.msg)};
          next_pb  = r.pb - 16'h0001;
          full_evt = (r.pb == 16'h0001) && r.cw[rtdm_pkg::CW_BFIE_BIT];
        end
      end
      default: begin
        buf_sel = r.pa[14:0];
      end
    endcase
  end

  always_comb begin
    next_r    = r;
    mem_addr  = r.ar_addr;
    mem_wdata = 16'h0000;
    mem_be    = 2'b00;
    mem_we    = 1'b0;
    msg_ready = 1'b0;
    next_r.done = 1'b0;
    next_r.irq  = 1'b0;
    // Enable pin filter: first stage feeds only the second
    next_r.ena_sync = {r.ena_sync[1:0], terminal_one_enable};
    if (r.ena_sync[2] == r.ena_sync[1]) begin
      next_r.ena_pin = r.ena_sync[1];
    end
    // Write and read channel capture
    if (awvalid && !r.aw_full) begin
      next_r.aw_full = 1'b1;
      next_r.aw_addr = awaddr[16:2];
    end
    if (wvalid && !r.w_full) begin
      next_r.w_full = 1'b1;
      next_r.w_data = wdata[15:0];
      next_r.w_be   = wstrb[1:0];
    end
    if (arvalid && !r.ar_full && !r.rvalid) begin
      next_r.ar_full = 1'b1;
      next_r.ar_addr = araddr[16:2];
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end
    case (r.st)
      rtdm_pkg::ST_CLR: begin
        // Clearing sweep serves as the self-test before ready
        mem_addr  = r.clr_addr;
        mem_we    = 1'b1;
        mem_be    = 2'b11;
        if (r.clr_addr == rtdm_pkg::LAST_WORD) begin
          next_r.ready = 1'b1;
          next_r.st    = rtdm_pkg::ST_IDLE;
        end else begin
          next_r.clr_addr = r.clr_addr + 15'h0001;
        end
      end
      rtdm_pkg::ST_IDLE: begin
        // Pending write first, so a following read sees it
        if (r.aw_full && r.w_full && !r.bvalid) begin
          next_r.aw_full = 1'b0;
          next_r.w_full  = 1'b0;
          next_r.bvalid  = 1'b1;
          if (r.aw_addr >= rtdm_pkg::REG_WORDS) begin
            mem_addr  = r.aw_addr;
            mem_wdata = r.w_data;
            mem_be    = r.w_be;
            mem_we    = 1'b1;
          end else if (r.aw_addr == rtdm_pkg::MCR_OFS) begin
            next_r.master_control_reg = merge(r.master_control_reg, r.w_data, r.w_be);
          end else if (r.aw_addr == rtdm_pkg::CFG_OFS) begin
            next_r.cfg = merge(r.cfg, r.w_data, r.w_be);
          end else if (r.aw_addr == rtdm_pkg::DTBASE_OFS) begin
            next_r.dtbase = merge(r.dtbase, r.w_data, r.w_be);
          end
        end else if (r.ar_full) begin
          next_r.ar_full = 1'b0;
          // RAM reads need one more cycle for the registered array
          if (r.ar_addr >= rtdm_pkg::REG_WORDS) begin
            next_r.st = rtdm_pkg::ST_HRD;
          end else begin
            next_r.rvalid = 1'b1;
            case (r.ar_addr)
              rtdm_pkg::MCR_OFS:    next_r.rdata = r.master_control_reg;
              rtdm_pkg::STATUS_OFS: next_r.rdata = {14'h0000, running, r.ready};
              rtdm_pkg::CFG_OFS:    next_r.rdata = r.cfg;
              rtdm_pkg::DTBASE_OFS: next_r.rdata = r.dtbase;
              default:              next_r.rdata = 16'h0000;
            endcase
          end
        end else if (running) begin
          // Messages only while the host port is quiet
          msg_ready = 1'b1;
          if (msg_valid) begin
            next_r.msg  = msg;
            next_r.desc = r.dtbase[14:0] + desc_ofs(msg);
            mem_addr    = r.dtbase[14:0] + desc_ofs(msg);
            next_r.st   = rtdm_pkg::ST_R1;
          end
        end
      end
      rtdm_pkg::ST_HRD: begin
        next_r.rdata  = mem_rdata;
        next_r.rvalid = 1'b1;
        next_r.st     = rtdm_pkg::ST_IDLE;
      end
      rtdm_pkg::ST_R1: begin
        mem_addr  = r.desc + 15'h0001;
        next_r.cw = mem_rdata;
        next_r.st = rtdm_pkg::ST_R2;
      end
      rtdm_pkg::ST_R2: begin
        mem_addr  = r.desc + 15'h0002;
        next_r.pa = mem_rdata;
        next_r.st = rtdm_pkg::ST_R3;
      end
      rtdm_pkg::ST_R3: begin
        mem_addr  = r.desc + 15'h0003;
        next_r.pb = mem_rdata;
        next_r.st = rtdm_pkg::ST_W0;
      end
      rtdm_pkg::ST_W0: begin
        // Control word goes back first so the flag shows soonest
        mem_addr  = r.desc;
        mem_wdata = next_cw;
        mem_be    = 2'b11;
        mem_we    = 1'b1;
        next_r.cw = next_cw;
        next_r.pa = next_pa;
        next_r.pb = next_pb;
        next_r.done_info = '{buf_addr: buf_sel, desc_addr: r.desc};
        next_r.irq = full_evt;
        next_r.st = rtdm_pkg::ST_W1;
      end
      rtdm_pkg::ST_W1: begin
        // Pointer A and index count written back in turn
        mem_addr  = r.desc + 15'h0001;
        mem_wdata = r.pa;
        mem_be    = 2'b11;
        mem_we    = 1'b1;
        next_r.st = rtdm_pkg::ST_W2;
      end
      rtdm_pkg::ST_W2: begin
        mem_addr    = r.desc + 15'h0002;
        mem_wdata   = r.pb;
        mem_be      = 2'b11;
        mem_we      = 1'b1;
        next_r.done = 1'b1;
        next_r.st   = rtdm_pkg::ST_IDLE;
      end
      default: begin
        next_r.st = rtdm_pkg::ST_IDLE;
      end
    endcase
  end

  // Registers reset here; the array is cleared by the sweep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r          <= '0;
      r.st       <= rtdm_pkg::ST_CLR;
      r.master_control_reg      <= rtdm_pkg::MCR_RST;
      r.cfg      <= rtdm_pkg::CFG_RST;
      r.dtbase   <= rtdm_pkg::DTBASE_RST;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // Shared RAM with byte lanes and registered read
  always_ff @(posedge aclk) begin
    if (ce) begin
      if (mem_we && mem_be[0]) begin
        mem[mem_addr][7:0] <= mem_wdata[7:0];
      end
      if (mem_we && mem_be[1]) begin
        mem[mem_addr][15:8] <= mem_wdata[15:8];
      end
      mem_rdata <= mem[mem_addr];
    end
  end

  // Handshake outputs straight from the capture flags
  always_comb begin
    awready      = !r.aw_full;
    wready       = !r.w_full;
    bresp        = 2'b00;
    bvalid       = r.bvalid;
    arready      = !r.ar_full && !r.rvalid;
    rdata        = {16'h0000, r.rdata};
    rresp        = 2'b00;
    rvalid       = r.rvalid;
    ready        = r.ready;
    buf_full_irq = r.irq;
    done_valid   = r.done;
    done_info    = r.done_info;
  end

endmodule // rtdm_top

// File: shared/rtdm_pkg.sv
// Constants, carriers and states for the terminal descriptor and buffer manager
package rtdm_pkg;
  localparam int unsigned RAM_WORDS       = 32768;
  localparam logic [14:0] LAST_WORD       = 15'h7FFF;
  localparam logic [14:0] REG_WORDS       = 15'h0050;
  // Register word offsets
  localparam logic [14:0] MCR_OFS         = 15'h0000;
  localparam logic [14:0] STATUS_OFS      = 15'h0001;
  localparam logic [14:0] CFG_OFS         = 15'h0017;
  localparam logic [14:0] DTBASE_OFS      = 15'h0019;
  // Register reset values
  localparam logic [15:0] MCR_RST         = 16'h0000;
  localparam logic [15:0] CFG_RST         = 16'h0000;
  localparam logic [15:0] DTBASE_RST      = 16'h0400;
  // Register fields
  localparam int unsigned MCR_ENA_BIT     = 6;
  localparam int unsigned MCR_STEX_BIT    = 7;
  localparam int unsigned CFG_NOTICE2_BIT = 0;
  localparam int unsigned ST_READY_BIT    = 0;
  localparam int unsigned ST_RUN_BIT      = 1;
  // Descriptor quadrant offsets from the table base
  localparam logic [14:0] Q_RX_SA         = 15'h0000;
  localparam logic [14:0] Q_TX_SA         = 15'h0080;
  localparam logic [14:0] Q_RX_MC         = 15'h0100;
  localparam logic [14:0] Q_TX_MC         = 15'h0180;
  localparam logic [4:0]  SA_MODE_LO      = 5'h00;
  localparam logic [4:0]  SA_MODE_HI      = 5'h1F;
  // Control word fields
  localparam int unsigned CW_BLOCK_ACCESSED_FLAG_BIT     = 12;
  localparam int unsigned CW_NPS_BIT      = 13;
  localparam int unsigned CW_BFIE_BIT     = 14;
  localparam logic [2:0]  SCH_PINGPONG    = 3'h0;
  localparam logic [2:0]  SCH_INDEXED     = 3'h1;
  localparam logic [2:0]  SCH_CIRC1       = 3'h2;
  localparam logic [2:0]  SCH_CIRC2       = 3'h3;
  localparam logic [15:0] MSG_INFO_WORDS  = 16'h0002;
  localparam logic [5:0]  FULL_WC         = 6'h20;

  typedef struct packed {
    logic       tx;
    logic       bcast;
    logic [4:0] subaddr_number;
    logic [4:0] wc_mode;
    logic       error;
  } rtdm_msg_s;

  typedef struct packed {
    logic [14:0] buf_addr;
    logic [14:0] desc_addr;
  } rtdm_done_s;

  typedef enum logic [3:0] {
    ST_CLR  = 4'h0,
    ST_IDLE = 4'h1,
    ST_HRD  = 4'h2,
    ST_R1   = 4'h3,
    ST_R2   = 4'h4,
    ST_R3   = 4'h5,
    ST_W0   = 4'h6,
    ST_W1   = 4'h7,
    ST_W2   = 4'h8
  } rtdm_st_e;
endpackage

// File: verification/rtdm_checker.sv
// Port-level checker for the descriptor manager
`timescale 1ns/10ps
module rtdm_checker (
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Watched ports
  input wire logic                terminal_one_enable,
  input wire logic                ready,
  input wire logic                buf_full_irq,
  input wire logic                msg_valid,
  input wire logic                msg_ready,
  input wire logic                done_valid,
  input wire logic                bvalid,
  input wire logic                bready,
  input wire logic [1:0]          bresp,
  input wire logic                rvalid,
  input wire logic                rready,
  input wire logic [31:0]         rdata,
  input wire logic [1:0]          rresp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_ready_gate; msg_ready |-> ready; endproperty
  a_ready_gate: assert property (p_ready_gate) else $error("message taken before ready");
  property p_ready_hold; ready |=> ready; endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
  property p_pin_gate; !terminal_one_enable [*5] |-> !msg_ready; endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("running with pin low");
  property p_done_lat; msg_valid && msg_ready |-> ##[7:8] done_valid; endproperty
  a_done_lat: assert property (p_done_lat) else $error("no buffer result");
  property p_done_pulse; done_valid |=> !done_valid; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("result longer than one cycle");
  property p_irq_done; buf_full_irq |-> ##[1:3] done_valid; endproperty
  a_irq_done: assert property (p_irq_done) else $error("full pulse without message");
  property p_irq_pulse; buf_full_irq |=> !buf_full_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("full pulse too long");
  property p_b_okay; bvalid |-> bresp == 2'h0; endproperty
  a_b_okay: assert property (p_b_okay) else $error("bad write response");
  property p_r_drop; rvalid && rready |=> !rvalid; endproperty
  a_r_drop: assert property (p_r_drop) else $error("read answer repeated");
  property p_r_width; rvalid |-> rdata[31:16] == 16'h0000; endproperty
  a_r_width: assert property (p_r_width) else $error("upper data not zero");
  property p_r_okay; rvalid |-> rresp == 2'h0; endproperty
  a_r_okay: assert property (p_r_okay) else $error("bad read response");
  c_msg: cover property (msg_valid && msg_ready);
  c_irq: cover property (buf_full_irq);
  c_wr: cover property (bvalid && bready);
endmodule // rtdm_checker
bind rtdm_top rtdm_checker rtdm_checker_inst (.aclk, .aresetn, .terminal_one_enable, .ready, .buf_full_irq,
  .msg_valid, .msg_ready, .done_valid, .bvalid, .bready, .bresp, .rvalid, .rready, .rdata, .rresp);

// File: verification/rtdm_host.sv
// Host processor model driving the register bus
`timescale 1ns/10ps
module rtdm_host (
  // Clock
  input wire logic   aclk,
  // Write side
  output logic [16:0] awaddr,
  output logic [2:0]  awprot,
  output logic        awvalid,
  input wire logic    awready,
  output logic [31:0] wdata,
  output logic [3:0]  wstrb,
  output logic        wvalid,
  input wire logic    wready,
  input wire logic    bvalid,
  output logic        bready,
  // Read side
  output logic [16:0] araddr,
  output logic [2:0]  arprot,
  output logic        arvalid,
  input wire logic    arready,
  input wire logic [31:0] rdata,
  input wire logic    rvalid,
  output logic        rready
);
  initial begin
    {awaddr, awprot, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arprot, arvalid, rready} = '0;
    wstrb = 4'hF;
  end
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    @(posedge aclk);
    awaddr <= {a, 2'h0};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~awaddr;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [14:0] a, output logic [15:0] d);
    @(posedge aclk);
    araddr <= {a, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~araddr;
      end
    end while (!rvalid);
    d = rdata[15:0];
    rready <= 1'b0;
  endtask
endmodule // rtdm_host

// File: verification/rtdm_top_tb.sv
// Self-checking bench for the descriptor manager
`timescale 1ns/10ps
module rtdm_top_tb;
  logic aclk, aresetn, ce, pin, msg_valid, awready, wready, bvalid, bready, arready, rvalid, rready;
  logic awvalid, wvalid, arvalid, ready, irq, msg_ready, done_valid;
  logic [16:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  rtdm_pkg::rtdm_msg_s msg;
  rtdm_pkg::rtdm_done_s done_info;
  logic [14:0] ba, da, sa, sb, xa, base;
  logic [5:0] n;
  logic seen;
  int fails, cmp_count, cyc, wait_n;
  rtdm_top rtdm_top_inst (.aclk, .aresetn, .ce, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .terminal_one_enable(pin), .ready, .buf_full_irq(irq), .msg_valid, .msg_ready, .msg, .done_valid, .done_info);
  rtdm_host rtdm_host_inst (.aclk, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rvalid, .rready);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  function automatic logic [14:0] desc(logic tx, logic [4:0] s, logic [4:0] w);
    if (s == rtdm_pkg::SA_MODE_LO || s == rtdm_pkg::SA_MODE_HI)
      return base + (tx ? rtdm_pkg::Q_TX_MC : rtdm_pkg::Q_RX_MC) + {8'h00, w, 2'h0};
    return base + (tx ? rtdm_pkg::Q_TX_SA : rtdm_pkg::Q_RX_SA) + {8'h00, s, 2'h0};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [14:0] a, input logic [15:0] e);
    logic [15:0] d;
    rtdm_host_inst.rd(a, d);
    chk(d, e);
  endtask
  task automatic send(input logic tx, input logic bc, input logic [4:0] s, input logic [4:0] w);
    msg <= {tx, bc, s, w, 1'b0};
    msg_valid <= 1'b1;
    seen = 1'b0;
    do @(posedge aclk); while (!msg_ready);
    msg_valid <= 1'b0;
    do begin
      @(posedge aclk);
      seen |= irq;
    end while (!done_valid);
    ba = done_info.buf_addr;
    da = done_info.desc_addr;
  endtask
  task automatic summarize;
    $display("Compared %0d, failed %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      $display("Error at %0t: timeout", $time);
      summarize();
    end
  end
  initial begin
    {aresetn, msg_valid, msg, fails, cmp_count, cyc} = '0;
    ce = 1'b1;
    pin = 1'b1;
    base = 15'h0400;
    void'($urandom(82524));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(ready, 1'b0);
    // Sweep paused by the enable: four edges before, the rest after
    ce <= 1'b0;
    repeat (50) @(posedge aclk);
    ce <= 1'b1;
    wait_n = 0;
    while (!ready) begin
      @(posedge aclk);
      wait_n++;
    end
    chk(16'(wait_n), 16'(rtdm_pkg::RAM_WORDS - 3));
    rchk(rtdm_pkg::STATUS_OFS, 16'h0001);
    rchk(rtdm_pkg::DTBASE_OFS, rtdm_pkg::DTBASE_RST);
    rchk(15'h0600, 16'h0000);
    rchk(15'(15'h0050 + $urandom_range(32000)), 16'h0000);
    rtdm_host_inst.wr(15'h0005, 16'hA5A5);
    rchk(15'h0005, 16'h0000);
    rtdm_host_inst.wr(rtdm_pkg::LAST_WORD, 16'h5A5A);
    rchk(rtdm_pkg::LAST_WORD, 16'h5A5A);
    rtdm_host_inst.wr(rtdm_pkg::MCR_OFS, 16'h0040);
    repeat (2) @(posedge aclk);
    chk(msg_ready, 1'b0);
    sa = 15'($urandom_range(15, 1));
    sb = 15'($urandom_range(30, 16));
    xa = desc(1'b0, sa[4:0], 5'h00);
    rtdm_host_inst.wr(xa, 16'h0000);
    rtdm_host_inst.wr(xa + 15'h1, 16'h2000);
    rtdm_host_inst.wr(xa + 15'h2, 16'h3000);
    rtdm_host_inst.wr(xa + 15'h3, 16'h4000);
    da = desc(1'b1, sb[4:0], 5'h00);
    rtdm_host_inst.wr(da, 16'h4001);
    rtdm_host_inst.wr(da + 15'h1, 16'h1000);
    rtdm_host_inst.wr(da + 15'h2, 16'h0002);
    rtdm_host_inst.wr(rtdm_pkg::MCR_OFS, 16'h00C0);
    repeat (2) @(posedge aclk);
    chk(msg_ready, 1'b1);
    for (int i = 0; i < 3; i++) begin
      send(1'b0, 1'b0, sa[4:0], 5'($urandom_range(31)));
      chk(ba, i[0] ? 16'h3000 : 16'h2000);
      chk(da, xa);
    end
    rchk(xa, 16'h3000);
    ba = 15'h1000;
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 6'h20 : 6'($urandom_range(31, 1));
      xa = ba;
      send(1'b1, 1'b0, sb[4:0], n[4:0]);
      chk(ba, xa);
      chk(seen, i == 1);
      if (i < 2) ba = xa + 15'(n) + 15'h2;
    end
    xa = desc(1'b1, sb[4:0], 5'h00);
    rchk(xa + 15'h1, ba);
    rchk(xa + 15'h2, 16'h0000);
    rtdm_host_inst.wr(xa + 15'h1, 16'h1000);
    rtdm_host_inst.wr(xa + 15'h2, 16'h0001);
    send(1'b1, 1'b0, sb[4:0], 5'h04);
    chk(ba, 16'h1000);
    chk(seen, 1'b1);
    rchk(xa + 15'h1, 16'h1006);
    for (int k = 0; k < 4; k++) begin
      n = 6'($urandom_range(31));
      send(k[0], 1'b0, k[1] ? 5'h1F : 5'h00, n[4:0]);
      chk(da, desc(k[0], k[1] ? 5'h1F : 5'h00, n[4:0]));
    end
    rtdm_host_inst.wr(rtdm_pkg::CFG_OFS, 16'h0001);
    send(1'b0, 1'b1, sa[4:0], 5'h03);
    chk(ba, 16'h4000);
    send(1'b0, 1'b0, sa[4:0], 5'h03);
    chk(ba, 16'h3000);
    xa = desc(1'b0, sa[4:0], 5'h00);
    rtdm_host_inst.wr(xa, {13'h0000, rtdm_pkg::SCH_INDEXED});
    send(1'b0, 1'b1, sa[4:0], 5'h03);
    chk(ba, 16'h4000);
    rchk(xa + 15'h2, 16'h3000);
    send(1'b0, 1'b0, sa[4:0], 5'h03);
    chk(ba, 16'h2000);
    rtdm_host_inst.wr(rtdm_pkg::CFG_OFS, 16'h0000);
    send(1'b0, 1'b1, sa[4:0], 5'h03);
    chk(ba, 16'h2005);
    base = 15'h0800;
    rtdm_host_inst.wr(rtdm_pkg::DTBASE_OFS, 16'h0800);
    send(1'b0, 1'b0, sa[4:0], 5'h01);
    chk(da, desc(1'b0, sa[4:0], 5'h01));
    pin <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(msg_ready, 1'b0);
    summarize();
  end
endmodule // rtdm_top_tb
